// >>> src/input_event_counter_pkg.sv
// Constants and types shared by the input event counter design
package input_event_counter_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int CNT_W = 32;
    localparam int DB_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 16;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] DEBOUNCE_TIME_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] DEBOUNCE_EN_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] COUNT_DIR_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] COUNT_EDGE_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] ALARM_EN_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] TERM_MODE_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] ALARM_CLEAR_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] COUNT_RELOAD_OFS = 8'h1c;
    localparam logic [ADDR_W-1:0] EVENT_STATUS_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] EVENT_MASK_OFS = 8'h24;
    localparam logic [ADDR_W-1:0] INPUT_STATE_OFS = 8'h28;
    localparam logic [1:0] COUNT_WIN = 2'h1;
    localparam logic [1:0] PRELOAD_WIN = 2'h2;
    localparam int WIN_POS = 6;
    localparam int IDX_POS = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DB_W-1:0] DEBOUNCE_TIME_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] DEBOUNCE_EN_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] COUNT_DIR_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] COUNT_EDGE_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] ALARM_EN_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] TERM_MODE_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] EVENT_MASK_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Terminal values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] TERM_UP = 32'hffff_ffff;
    localparam logic [CNT_W-1:0] TERM_DOWN = 32'h0000_0000;

    // ------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT,
        ST_IDLE,
        ST_FETCH,
        ST_UPDATE
    } engine_state_t;

    // Sticky flag update, the set wins over the clear
    function automatic logic [NUM_CH-1:0] sticky(input logic [NUM_CH-1:0] cur,
                                                 input logic [NUM_CH-1:0] set,
                                                 input logic [NUM_CH-1:0] clr);
        sticky = set | (cur & ~clr);
    endfunction

endpackage

// >>> src/debounce_filter.sv
// Level debounce filter for one input channel
`timescale 1ns/1ps
module debounce_filter
    import input_event_counter_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic tick_ms,
    input wire logic enable,
    input wire logic [DB_W-1:0] time_ms,
    // Levels
    input wire logic raw_in,
    output logic level_out
);

    logic level_reg;
    logic level_next;
    logic [DB_W-1:0] cnt_reg;
    logic [DB_W-1:0] cnt_next;

    assign level_out = level_reg;

    always_comb begin
        level_next = level_reg;
        cnt_next = cnt_reg;
        if (!enable || time_ms == '0) begin
            level_next = raw_in;
            cnt_next = '0;
        end else if (raw_in == level_reg) begin
            cnt_next = '0;
        end else if (tick_ms) begin
            if (cnt_reg + 16'h0001 >= time_ms) begin
                level_next = raw_in;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            level_reg <= level_next;
            cnt_reg <= cnt_next;
        end
    end

endmodule

// >>> src/count_memory.sv
// Word memory with one write port and two registered read ports
`timescale 1ns/1ps
module count_memory
    import input_event_counter_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [CH_W-1:0] wr_addr,
    input wire logic [CNT_W-1:0] wr_data,
    // Read port a
    input wire logic [CH_W-1:0] rd_addr_a,
    output logic [CNT_W-1:0] rd_data_a,
    // Read port b
    input wire logic [CH_W-1:0] rd_addr_b,
    output logic [CNT_W-1:0] rd_data_b
);

    logic [CNT_W-1:0] mem [NUM_CH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end

endmodule

// >>> src/input_event_counter.sv
// Input event counters with debounce, preload, alarms and event interrupt
//
// Behaviour
// - One 32-bit count per channel, kept across reset when retention is asked.
// - Per-channel debounce enable filters transitions before counting.
// - One shared debounce time, 0 to 65535 ms, used by all.
// - Per-channel direction: up by default, or down from preload.
// - Per-channel count edge: falling by default, or rising.
// - Count reloads its preload on software reset or rollover.
// - Alarm enable, off at reset, lets terminal count drive the alarm.
// - Terminal value is 0 counting down, all ones counting up.
// - Auto mode clears alarm on next event; latch holds until cleared.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module input_event_counter
    import input_event_counter_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Field inputs
    input wire logic [NUM_CH-1:0] field_in,
    input wire logic keep_counts,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Alarms and interrupt
    output logic [NUM_CH-1:0] alarm_out,
    output logic irq
);

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_reg;
    logic [TICK_W-1:0] tick_cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + 16'h0001;
        if (tick_cnt_reg == TICK_W'(TICK_LEN - 1)) begin
            tick_cnt_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // Control registers and bus slave
    // ------------------------------------------------------------
    logic [DB_W-1:0] db_time_reg, db_time_next;
    logic [NUM_CH-1:0] db_en_reg, db_en_next;
    logic [NUM_CH-1:0] dir_reg, dir_next;
    logic [NUM_CH-1:0] edge_reg, edge_next;
    logic [NUM_CH-1:0] alarm_en_reg, alarm_en_next;
    logic [NUM_CH-1:0] term_mode_reg, term_mode_next;
    logic [NUM_CH-1:0] mask_reg, mask_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0] rsel_reg, rsel_next;
    logic [NUM_CH-1:0] alarm_clr_w, reload_w, status_clr_w;
    logic [NUM_CH-1:0] level, status_reg, alarm_reg, reload_pend_reg;
    logic [CNT_W-1:0] cnt_qa, cnt_qb, pre_qa, pre_qb;
    logic [1:0] win;
    logic [CH_W-1:0] win_idx;
    logic pre_wr;

    assign win = reg_addr[WIN_POS+1:WIN_POS];
    assign win_idx = reg_addr[IDX_POS+CH_W-1:IDX_POS];
    assign pre_wr = reg_wr && win == PRELOAD_WIN;

    always_comb begin
        db_time_next = db_time_reg;
        db_en_next = db_en_reg;
        dir_next = dir_reg;
        edge_next = edge_reg;
        alarm_en_next = alarm_en_reg;
        term_mode_next = term_mode_reg;
        mask_next = mask_reg;
        alarm_clr_w = '0;
        reload_w = '0;
        status_clr_w = '0;
        rdata_next = '0;
        rsel_next = 2'h0;
        if (reg_wr) begin
            case (reg_addr)
                DEBOUNCE_TIME_OFS: db_time_next = reg_wdata[DB_W-1:0];
                DEBOUNCE_EN_OFS: db_en_next = reg_wdata[NUM_CH-1:0];
                COUNT_DIR_OFS: dir_next = reg_wdata[NUM_CH-1:0];
                COUNT_EDGE_OFS: edge_next = reg_wdata[NUM_CH-1:0];
                ALARM_EN_OFS: alarm_en_next = reg_wdata[NUM_CH-1:0];
                TERM_MODE_OFS: term_mode_next = reg_wdata[NUM_CH-1:0];
                ALARM_CLEAR_OFS: alarm_clr_w = reg_wdata[NUM_CH-1:0];
                COUNT_RELOAD_OFS: reload_w = reg_wdata[NUM_CH-1:0];
                EVENT_STATUS_OFS: status_clr_w = reg_wdata[NUM_CH-1:0];
                EVENT_MASK_OFS: mask_next = reg_wdata[NUM_CH-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            if (win == COUNT_WIN) begin
                rsel_next = COUNT_WIN;
            end else if (win == PRELOAD_WIN) begin
                rsel_next = PRELOAD_WIN;
            end else begin
                case (reg_addr)
                    DEBOUNCE_TIME_OFS: rdata_next = {16'h0000, db_time_reg};
                    DEBOUNCE_EN_OFS: rdata_next = {16'h0000, db_en_reg};
                    COUNT_DIR_OFS: rdata_next = {16'h0000, dir_reg};
                    COUNT_EDGE_OFS: rdata_next = {16'h0000, edge_reg};
                    ALARM_EN_OFS: rdata_next = {16'h0000, alarm_en_reg};
                    TERM_MODE_OFS: rdata_next = {16'h0000, term_mode_reg};
                    ALARM_CLEAR_OFS: rdata_next = {16'h0000, alarm_reg};
                    COUNT_RELOAD_OFS: rdata_next = {16'h0000, reload_pend_reg};
                    EVENT_STATUS_OFS: rdata_next = {16'h0000, status_reg};
                    EVENT_MASK_OFS: rdata_next = {16'h0000, mask_reg};
                    INPUT_STATE_OFS: rdata_next = {16'h0000, level};
                    default: rdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            db_time_reg <= DEBOUNCE_TIME_RST;
            db_en_reg <= DEBOUNCE_EN_RST;
            dir_reg <= COUNT_DIR_RST;
            edge_reg <= COUNT_EDGE_RST;
            alarm_en_reg <= ALARM_EN_RST;
            term_mode_reg <= TERM_MODE_RST;
            mask_reg <= EVENT_MASK_RST;
            rdata_reg <= '0;
            rsel_reg <= 2'h0;
        end else begin
            db_time_reg <= db_time_next;
            db_en_reg <= db_en_next;
            dir_reg <= dir_next;
            edge_reg <= edge_next;
            alarm_en_reg <= alarm_en_next;
            term_mode_reg <= term_mode_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            rsel_reg <= rsel_next;
        end
    end

    assign reg_rdata = (rsel_reg == COUNT_WIN) ? cnt_qb :
                       (rsel_reg == PRELOAD_WIN) ? pre_qb : rdata_reg;

    // ------------------------------------------------------------
    // Debounce and edge detection
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] prev_reg, hit;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_filter
        debounce_filter u_filter (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .tick_ms(tick_reg),
            .enable(db_en_reg[i]),
            .time_ms(db_time_reg),
            .raw_in(field_in[i]),
            .level_out(level[i])
        );
    end

    assign hit = (edge_reg & level & ~prev_reg) | (~edge_reg & ~level & prev_reg);

    // ------------------------------------------------------------
    // Count engine
    // ------------------------------------------------------------
    engine_state_t state_reg, state_next;
    logic [CH_W-1:0] ch_reg, ch_next;
    logic [NUM_CH-1:0] event_pend_reg, event_pend_next;
    logic [NUM_CH-1:0] reload_pend_next, status_next, alarm_next;
    logic [NUM_CH-1:0] done_ev, done_rl, term_set, alarm_set, alarm_auto_clr;
    logic [NUM_CH-1:0] pend_any;
    logic cnt_wr;
    logic [CNT_W-1:0] cnt_wdata, pre_wdata;
    logic [CH_W-1:0] pre_waddr;
    logic pre_we;
    logic irq_reg, irq_next;

    assign pend_any = event_pend_reg | reload_pend_reg;

    always_comb begin
        state_next = state_reg;
        ch_next = ch_reg;
        done_ev = '0;
        done_rl = '0;
        term_set = '0;
        alarm_set = '0;
        alarm_auto_clr = '0;
        cnt_wr = 1'b0;
        cnt_wdata = COUNT_RST;
        case (state_reg)
            ST_INIT: begin
                cnt_wr = !keep_counts;
                ch_next = ch_reg + 4'h1;
                if (keep_counts || ch_reg == 4'(NUM_CH - 1)) begin
                    state_next = ST_IDLE;
                    ch_next = '0;
                end
            end
            ST_IDLE: begin
                for (int i = NUM_CH - 1; i >= 0; i--) begin
                    if (pend_any[i]) begin
                        ch_next = 4'(i);
                    end
                end
                if (|pend_any) begin
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH: state_next = ST_UPDATE;
            ST_UPDATE: begin
                state_next = ST_IDLE;
                cnt_wr = 1'b1;
                if (reload_pend_reg[ch_reg]) begin
                    done_rl[ch_reg] = 1'b1;
                    cnt_wdata = pre_qa;
                end else begin
                    done_ev[ch_reg] = 1'b1;
                    alarm_auto_clr[ch_reg] = !term_mode_reg[ch_reg];
                    if (!dir_reg[ch_reg]) begin
                        if (cnt_qa == TERM_UP) begin
                            cnt_wdata = pre_qa;
                        end else begin
                            cnt_wdata = cnt_qa + 32'h0000_0001;
                            term_set[ch_reg] = (cnt_wdata == TERM_UP);
                        end
                    end else begin
                        if (cnt_qa == TERM_DOWN) begin
                            cnt_wdata = pre_qa;
                        end else begin
                            cnt_wdata = cnt_qa - 32'h0000_0001;
                            term_set[ch_reg] = (cnt_wdata == TERM_DOWN);
                        end
                    end
                    alarm_set = term_set & alarm_en_reg;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        event_pend_next = sticky(event_pend_reg, hit, done_ev);
        reload_pend_next = sticky(reload_pend_reg, reload_w, done_rl);
        status_next = sticky(status_reg, term_set, status_clr_w);
        alarm_next = sticky(alarm_reg, alarm_set, alarm_clr_w | alarm_auto_clr) & alarm_en_next;
        irq_next = |(status_next & mask_next);
        pre_we = pre_wr || (state_reg == ST_INIT && !keep_counts);
        pre_waddr = (state_reg == ST_INIT) ? ch_reg : win_idx;
        pre_wdata = (state_reg == ST_INIT) ? COUNT_RST : reg_wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
            ch_reg <= '0;
            prev_reg <= '0;
            event_pend_reg <= '0;
            reload_pend_reg <= '0;
            status_reg <= '0;
            alarm_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ch_reg <= ch_next;
            prev_reg <= level;
            event_pend_reg <= event_pend_next;
            reload_pend_reg <= reload_pend_next;
            status_reg <= status_next;
            alarm_reg <= alarm_next;
            irq_reg <= irq_next;
        end
    end

    assign alarm_out = alarm_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------
    // Count and preload storage
    // ------------------------------------------------------------
    count_memory u_count_mem (
        .sys_clk(sys_clk),
        .wr_en(cnt_wr),
        .wr_addr(ch_reg),
        .wr_data(cnt_wdata),
        .rd_addr_a(ch_reg),
        .rd_data_a(cnt_qa),
        .rd_addr_b(win_idx),
        .rd_data_b(cnt_qb)
    );

    count_memory u_preload_mem (
        .sys_clk(sys_clk),
        .wr_en(pre_we),
        .wr_addr(pre_waddr),
        .wr_data(pre_wdata),
        .rd_addr_a(ch_reg),
        .rd_data_a(pre_qa),
        .rd_addr_b(win_idx),
        .rd_data_b(pre_qb)
    );

endmodule

// >>> test/input_event_counter_checker.sv
// Port checker for the input event counter, bound to its top module
`timescale 1ns/1ps
module input_event_counter_checker
    import input_event_counter_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Alarms and interrupt
    input wire logic [NUM_CH-1:0] alarm_out,
    input wire logic irq
);
    // --------------------------------------------
    // Shadow registers
    // --------------------------------------------
    logic [DB_W-1:0] db_reg, db_next;
    logic [NUM_CH-1:0] en_reg, en_next, mask_reg, mask_next;
    always_comb begin
        db_next = db_reg;
        en_next = en_reg;
        mask_next = mask_reg;
        if (reg_wr && reg_addr == DEBOUNCE_TIME_OFS) db_next = reg_wdata[DB_W-1:0];
        if (reg_wr && reg_addr == ALARM_EN_OFS) en_next = reg_wdata[NUM_CH-1:0];
        if (reg_wr && reg_addr == EVENT_MASK_OFS) mask_next = reg_wdata[NUM_CH-1:0];
        if (!rst_n) begin
            db_next = '0;
            en_next = '0;
            mask_next = '0;
        end
    end
    always_ff @(posedge sys_clk) begin
        db_reg <= db_next;
        en_reg <= en_next;
        mask_reg <= mask_next;
    end
    // --------------------------------------------
    // Assertions
    // --------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> alarm_out == '0 && !irq && reg_rdata == '0) else $error("outputs not quiet");
    a_db_readback: assert property ($past(reg_rd) && $past(reg_addr) == DEBOUNCE_TIME_OFS
        |-> reg_rdata[DB_W-1:0] == $past(db_reg)) else $error("debounce time readback");
    a_en_readback: assert property ($past(reg_rd) && $past(reg_addr) == ALARM_EN_OFS
        |-> reg_rdata[NUM_CH-1:0] == $past(en_reg)) else $error("alarm enable readback");
    a_ctl_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) <= INPUT_STATE_OFS
        |-> reg_rdata[31:16] == '0) else $error("upper control bits set");
    a_alarm_needs_en: assert property (
        (alarm_out & ~en_reg & ~$past(en_reg)) == '0) else $error("alarm while disabled");
    a_irq_needs_mask: assert property (
        irq |-> mask_reg != '0) else $error("irq with empty mask");
    a_alarm_clear_wr: assert property (reg_wr && reg_addr == ALARM_CLEAR_OFS
        |=> (alarm_out & $past(reg_wdata[NUM_CH-1:0])) == '0) else $error("alarm not cleared");
    a_status_clear_wr: assert property (reg_wr && reg_addr == EVENT_STATUS_OFS
        && reg_wdata[NUM_CH-1:0] == 16'hffff |=> ##1 !irq) else $error("irq not cleared");
    c_irq_rise: cover property ($rose(irq));
    c_alarm_rise: cover property ($rose(alarm_out[3]));
    c_count_read: cover property (reg_rd && reg_addr[7:6] == COUNT_WIN);
endmodule

bind input_event_counter input_event_counter_checker input_event_counter_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_out(alarm_out),
    .irq(irq));

// >>> test/field_source.sv
// Field line model giving single pulses with a minimum spacing
`timescale 1ns/1ps
module field_source
    import input_event_counter_pkg::*;
#(
    parameter int GAP = 150
)
(
    // Clock
    input wire logic sys_clk,
    // Pulse request
    input wire logic go,
    input wire logic [CH_W-1:0] ch,
    input wire logic [15:0] len,
    // Field lines
    output logic [NUM_CH-1:0] field_in,
    output logic busy
);
    logic [NUM_CH-1:0] line_reg = '0;
    logic busy_reg = 1'b0;
    int cnt = 0;
    assign field_in = line_reg;
    assign busy = busy_reg;
    // Lines idle at the pull-down level; spacing keeps the rate low
    always @(posedge sys_clk) begin
        if (go && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt <= len + GAP;
            line_reg[ch] <= 1'b1;
        end else if (busy_reg) begin
            cnt <= cnt - 1;
            if (cnt == GAP) line_reg <= '0;
            if (cnt == 1) busy_reg <= 1'b0;
        end
    end
endmodule

// >>> test/input_event_counter_tb.sv
// Self-checking testbench for the input event counter
`timescale 1ns/1ps
module input_event_counter_tb
    import input_event_counter_pkg::*;
;
    localparam int TL = 10;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic keep_counts = 1'b0;
    logic [NUM_CH-1:0] field_in;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_CH-1:0] alarm_out;
    logic irq;
    logic go = 1'b0;
    logic [CH_W-1:0] ch = '0;
    logic [15:0] len = '0;
    logic busy;
    int err_count = 0;
    int checks_done = 0;

    input_event_counter #(.TICK_LEN(TL)) input_event_counter_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .field_in(field_in), .keep_counts(keep_counts),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .alarm_out(alarm_out), .irq(irq));
    field_source #(.GAP(150)) field_source_inst (
        .sys_clk(sys_clk), .go(go), .ch(ch), .len(len), .field_in(field_in), .busy(busy));

    initial forever #12.5 sys_clk = ~sys_clk;

    // --------------------------------------------
    // Helpers
    // --------------------------------------------
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk_word(reg_rdata, exp);
    endtask
    function automatic logic [ADDR_W-1:0] wa(input logic [1:0] w, input int c);
        return {w, c[CH_W-1:0], 2'b00};
    endfunction
    task pulse(input int c, input int n);
        @(posedge sys_clk);
        go <= 1'b1;
        ch <= c[CH_W-1:0];
        len <= n[15:0];
        @(posedge sys_clk);
        go <= 1'b0;
    endtask
    task wait_idle;
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1 k++;
        end while (busy !== 1'b0 && k < 2000);
        chk_flag(busy, 1'b0);
    endtask
    task do_reset;
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(20);
    endtask

    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    task t_defaults;
        for (int a = 0; a <= 8'h2c; a += 4) rdchk(a[ADDR_W-1:0], '0);
        chk_word({16'h0, alarm_out}, '0);
        $display("test defaults done");
    endtask
    task t_edge(input int c, input logic rise);
        if (rise) wr(COUNT_EDGE_OFS, 32'h1 << c);
        pulse(c, 50);
        cyc(25);
        rdchk(wa(COUNT_WIN, c), {31'h0, rise});
        wait_idle;
        rdchk(wa(COUNT_WIN, c), 32'h1);
        $display("test edge done");
    endtask
    task t_down;
        wr(wa(PRELOAD_WIN, 2), 32'h2);
        wr(COUNT_RELOAD_OFS, 32'h4);
        cyc(8);
        rdchk(wa(COUNT_WIN, 2), 32'h2);
        wr(COUNT_DIR_OFS, 32'h4);
        wr(ALARM_EN_OFS, 32'h4);
        wr(EVENT_MASK_OFS, 32'h4);
        pulse(2, 20);
        wait_idle;
        rdchk(wa(COUNT_WIN, 2), 32'h1);
        chk_flag(alarm_out[2], 1'b0);
        pulse(2, 20);
        wait_idle;
        rdchk(wa(COUNT_WIN, 2), 32'h0);
        chk_flag(alarm_out[2], 1'b1);
        chk_flag(irq, 1'b1);
        pulse(2, 20);
        wait_idle;
        rdchk(wa(COUNT_WIN, 2), 32'h2);
        chk_flag(alarm_out[2], 1'b0);
        wr(EVENT_STATUS_OFS, 32'hffff);
        cyc(3);
        #1 chk_flag(irq, 1'b0);
        $display("test down done");
    endtask
    task t_latch;
        wr(wa(PRELOAD_WIN, 3), 32'hffff_fffe);
        wr(COUNT_RELOAD_OFS, 32'h8);
        wr(ALARM_EN_OFS, 32'hc);
        wr(TERM_MODE_OFS, 32'h8);
        cyc(8);
        pulse(3, 20);
        wait_idle;
        rdchk(wa(COUNT_WIN, 3), 32'hffff_ffff);
        chk_flag(alarm_out[3], 1'b1);
        chk_flag(irq, 1'b0);
        pulse(3, 20);
        wait_idle;
        rdchk(wa(COUNT_WIN, 3), 32'hffff_fffe);
        chk_flag(alarm_out[3], 1'b1);
        wr(ALARM_CLEAR_OFS, 32'h8);
        #1 chk_flag(alarm_out[3], 1'b0);
        $display("test latch done");
    endtask
    task t_debounce;
        wr(DEBOUNCE_TIME_OFS, 32'h1_ffff);
        rdchk(DEBOUNCE_TIME_OFS, 32'hffff);
        wr(DEBOUNCE_TIME_OFS, 32'h3);
        wr(DEBOUNCE_EN_OFS, 32'h10);
        pulse(4, 12);
        wait_idle;
        pulse(5, 12);
        cyc(6);
        rdchk(wa(COUNT_WIN, 5), 32'h0);
        wait_idle;
        rdchk(wa(COUNT_WIN, 4), 32'h0);
        rdchk(wa(COUNT_WIN, 5), 32'h1);
        pulse(4, 60);
        wait_idle;
        rdchk(wa(COUNT_WIN, 4), 32'h1);
        wr(DEBOUNCE_TIME_OFS, 32'h0);
        pulse(4, 3);
        wait_idle;
        rdchk(wa(COUNT_WIN, 4), 32'h2);
        $display("test debounce done");
    endtask
    task t_keep;
        @(posedge sys_clk);
        keep_counts <= 1'b1;
        do_reset;
        rdchk(wa(COUNT_WIN, 0), 32'h1);
        rdchk(wa(COUNT_WIN, 3), 32'hffff_fffe);
        keep_counts <= 1'b0;
        do_reset;
        rdchk(wa(COUNT_WIN, 0), 32'h0);
        rdchk(wa(PRELOAD_WIN, 2), 32'h0);
        rdchk(ALARM_EN_OFS, 32'h0);
        $display("test keep done");
    endtask

    initial begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(17);
        t_defaults;
        t_edge(0, 1'b0);
        t_edge(1, 1'b1);
        t_down;
        t_latch;
        t_debounce;
        t_keep;
        wrap_up;
    end
    initial begin
        #(40000 * CLK_PERIOD_NS);
        err_count++;
        wrap_up;
    end
endmodule
